// ---- logic/prs_top.sv ----
// peripheral group soft reset controller with an APB register slave
//
// Summary of operation
// RULE1: bit 7 resets LCD, upper I2S, UART, SPI
// RULE2: bit 5 resets MMC/SD and lower I2S
// RULE3: bit 4 resets all four DMA controllers
// RULE4: bit 3 resets the USB controller
// RULE5: bit 2 resets converter and analog registers
// RULE6: bit 1 resets memory interface and timers
// RULE7: bit 0 resets the I2C controller
// RULE8: writing one starts that group's reset
// RULE9: writing zero does nothing, never cancels
// RULE10: bit reads zero once group released
// RULE11: bit reads one while group held
// RULE12: software leaves a held group alone
// RULE13: software writes zero to reserved bits
// RULE14: hold reset for duration count, then clear
// RULE15: software programs duration of eight or more
// RULE16: group reset outputs are active low
// RULE17: several bits in one write start together
`timescale 1ns/1ps

module prs_top #(
    parameter int DUR_W = prs_pkg::PRS_DURATION_W
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [prs_pkg::PRS_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // group reset lines, low while the group is held
    output logic group_four_reset_n,
    output logic group_three_reset_n,
    output logic dma_reset_n,
    output logic usb_reset_n,
    output logic analog_converter_reset_n,
    output logic group_one_reset_n,
    output logic i2c_reset_n
);

    localparam int NG = prs_pkg::PRS_GROUPS;
    localparam int LO = prs_pkg::PRS_LANE_LO;
    localparam int HI = prs_pkg::PRS_LANE_HI;

    // refuse widths the register and the counters cannot serve
    if (DUR_W < 1 || DUR_W > prs_pkg::PRS_DURATION_W) begin : g_bad_width
        $error("prs_top: DUR_W must lie between 1 and 16");
    end

    // every group bit must sit on a writable position of the register
    for (genvar g = 0; g < NG; g++) begin : g_map_check
        localparam int POS = prs_pkg::PRS_GROUP_BIT[g];
        localparam int REG_W = $bits(prs_pkg::PRS_CONTROL_MASK);
        if (POS < 0 || POS >= REG_W) begin : g_bad_pos
            $error("prs_top: group bit lies outside the register");
        end else if (!prs_pkg::PRS_CONTROL_MASK[POS]) begin : g_bad_bit
            $error("prs_top: group bit falls on a reserved position");
        end
    end

    // one group for each writable bit of the register
    if ($countones(prs_pkg::PRS_CONTROL_MASK) != NG) begin : g_bad_count
        $error("prs_top: group count differs from the writable bits");
    end

    // bus phase decode
    logic setup_phase;
    logic access_done;
    logic hit_duration;
    logic hit_control;
    logic wr_duration_reg;
    logic wr_control_reg;
    logic ctl_write;

    // register state
    logic [DUR_W-1:0] duration_reg;
    logic [DUR_W-1:0] duration_next;
    logic [NG-1:0] held_reg;
    logic [NG-1:0] held_next;
    logic [NG-1:0] trigger;
    logic [NG-1:0] expire;
    logic [NG-1:0] reset_n_reg;

    // bus answer registers
    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;

    // the access is taken only in the cycle where pready is already high
    assign setup_phase = psel && !penable;
    assign access_done = psel && penable && pready_reg;
    assign ctl_write = access_done && wr_control_reg;

    // address decode of the two registers
    always_comb begin
        hit_duration = 1'b0;
        hit_control = 1'b0;
        if (paddr == prs_pkg::PRS_ADDR_DURATION) begin
            hit_duration = 1'b1;
        end else if (paddr == prs_pkg::PRS_ADDR_CONTROL) begin
            hit_control = 1'b1;
        end
    end

    // write intent decided at setup, from the same decode that gives the
    // error answer, so a write never lands on an unmapped address
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wr_duration_reg <= 1'b0;
            wr_control_reg <= 1'b0;
        end else if (setup_phase) begin
            wr_duration_reg <= pwrite && hit_duration;
            wr_control_reg <= pwrite && hit_control && pstrb[LO];
        end else begin
            wr_duration_reg <= 1'b0;
            wr_control_reg <= 1'b0;
        end
    end

    // pready rises one cycle after setup, giving one access cycle per
    // transfer; registering it keeps the output glitch free
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pready_reg <= 1'b0;
        end else if (setup_phase) begin
            pready_reg <= 1'b1;
        end else begin
            pready_reg <= 1'b0;
        end
    end

    // an unmapped address answers with an error, nothing is stored
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pslverr_reg <= 1'b0;
        end else if (setup_phase) begin
            pslverr_reg <= !(hit_duration || hit_control);
        end else begin
            pslverr_reg <= 1'b0;
        end
    end

    // read data is picked at setup so it is stable through access
    always_comb begin
        prdata_next = 32'h0000_0000;
        if (hit_duration) begin
            prdata_next[DUR_W-1:0] = duration_reg;
        end else if (hit_control) begin
            for (int g = 0; g < NG; g++) begin
                prdata_next[prs_pkg::PRS_GROUP_BIT[g]] = held_reg[g]; // RULE11
            end
        end
    end

    // read data register, cleared outside reads to keep the bus quiet
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            prdata_reg <= 32'h0000_0000;
        end else if (setup_phase && !pwrite) begin
            prdata_reg <= prdata_next;
        end else if (access_done) begin
            prdata_reg <= 32'h0000_0000;
        end
    end

    // duration field, written per byte lane as strobed
    always_comb begin
        logic [15:0] wide;
        wide = 16'h0000;
        wide[DUR_W-1:0] = duration_reg;
        if (pstrb[LO]) begin
            wide[7:0] = pwdata[7:0];
        end
        if (pstrb[HI]) begin
            wide[15:8] = pwdata[15:8];
        end
        duration_next = wide[DUR_W-1:0];
    end

    // duration register; a new value only times resets started later
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            duration_reg <= prs_pkg::PRS_DURATION_RESET[DUR_W-1:0];
        end else if (access_done && wr_duration_reg) begin
            duration_reg <= duration_next;
        end
    end

    // a one in a group bit of the low lane starts that group; zeros and
    // reserved bits are ignored so a zero write cannot cut a reset short
    always_comb begin
        trigger = '0;
        if (ctl_write) begin
            for (int g = 0; g < NG; g++) begin
                trigger[g] = pwdata[prs_pkg::PRS_GROUP_BIT[g]]; // RULE8 RULE17
            end
        end
    end

    // one down-counter per group, all loaded from the same duration
    for (genvar g = 0; g < NG; g++) begin : g_group
        logic [DUR_W-1:0] count_reg;
        logic [DUR_W-1:0] load;

        // a zero duration still gives a one-cycle pulse
        always_comb begin
            if (duration_reg == '0) begin
                load = DUR_W'(1); // RULE14
            end else begin
                load = duration_reg; // RULE14
            end
        end

        // last held cycle when the count has run down to one
        assign expire[g] = held_reg[g] && (count_reg == DUR_W'(1));

        // the count is restarted by a retrigger from the current duration, so a reset ends sooner only if that duration was lowered
        always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
                count_reg <= '0;
            end else if (trigger[g]) begin
                count_reg <= load; // RULE14 RULE9
            end else if (held_reg[g] && count_reg != '0) begin
                count_reg <= count_reg - DUR_W'(1); // RULE14
            end
        end

        // trigger wins over expiry in the same cycle
        always_comb begin
            if (trigger[g]) begin
                held_next[g] = 1'b1; // RULE8
            end else if (expire[g]) begin
                held_next[g] = 1'b0; // RULE10 RULE14
            end else begin
                held_next[g] = held_reg[g]; // RULE9
            end
        end
    end

    // status of each group as read back by software
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            held_reg <= prs_pkg::PRS_CONTROL_RESET[NG-1:0];
        end else begin
            held_reg <= held_next; // RULE10 RULE11
        end
    end

    // output lines track status exactly, from their own flops
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reset_n_reg <= '1;
        end else begin
            reset_n_reg <= ~held_next; // RULE16
        end
    end

    // bus outputs
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;

    // group lines; index order follows the bit map in the package
    assign i2c_reset_n = reset_n_reg[0]; // RULE7
    assign group_one_reset_n = reset_n_reg[1]; // RULE6
    assign analog_converter_reset_n = reset_n_reg[2]; // RULE5
    assign usb_reset_n = reset_n_reg[3]; // RULE4
    assign dma_reset_n = reset_n_reg[4]; // RULE3
    assign group_three_reset_n = reset_n_reg[5]; // RULE2
    assign group_four_reset_n = reset_n_reg[6]; // RULE1

endmodule : prs_top

// ---- logic/prs_pkg.sv ----
// constants for the peripheral group soft reset block
package prs_pkg;

    // register indices as printed; the byte address is four times the index
    localparam logic [15:0] PRS_IDX_DURATION = 16'h1C04;
    localparam logic [15:0] PRS_IDX_CONTROL = 16'h1C05;
    localparam logic [17:0] PRS_ADDR_DURATION = {PRS_IDX_DURATION, 2'b00};
    localparam logic [17:0] PRS_ADDR_CONTROL = {PRS_IDX_CONTROL, 2'b00};

    // width of the APB address bus that the slave decodes
    localparam int PRS_ADDR_W = 18;

    // number of peripheral groups with a reset line
    localparam int PRS_GROUPS = 7;

    // control register bit positions, group index 0 to 6
    localparam int PRS_BIT_I2C = 0;
    localparam int PRS_BIT_GROUP_ONE = 1;
    localparam int PRS_BIT_ANALOG = 2;
    localparam int PRS_BIT_USB = 3;
    localparam int PRS_BIT_DMA = 4;
    localparam int PRS_BIT_GROUP_THREE = 5;
    localparam int PRS_BIT_GROUP_FOUR = 7;

    // map from group index to control register bit
    localparam int PRS_GROUP_BIT [PRS_GROUPS] = '{
        PRS_BIT_I2C, PRS_BIT_GROUP_ONE, PRS_BIT_ANALOG, PRS_BIT_USB,
        PRS_BIT_DMA, PRS_BIT_GROUP_THREE, PRS_BIT_GROUP_FOUR
    };

    // writable group bits of the control register; 15-8 and 6 reserved
    localparam logic [15:0] PRS_CONTROL_MASK = 16'h00BF;

    // reset values
    localparam logic [15:0] PRS_DURATION_RESET = 16'h0008;
    localparam logic [15:0] PRS_CONTROL_RESET = 16'h0000;

    // least duration that software is expected to program
    localparam logic [15:0] PRS_DURATION_MIN_ADVISED = 16'h0008;

    // documented width of the duration counter field
    localparam int PRS_DURATION_W = 16;

    // byte lanes of the 16-bit registers inside the 32-bit data word
    localparam int PRS_LANE_LO = 0;
    localparam int PRS_LANE_HI = 1;

endpackage : prs_pkg

// ---- test/prs_top_checker.sv ----
// checker for the peripheral group soft reset block
`timescale 1ns/1ps
module prs_top_checker #(
    parameter int DUR_W = 16
) (
    // clock and reset
    input logic clk_sys,
    input logic rst_n,
    // apb
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [17:0] paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic [3:0] pstrb,
    input logic pready,
    input logic pslverr,
    // group reset lines
    input logic group_four_reset_n,
    input logic group_three_reset_n,
    input logic dma_reset_n,
    input logic usb_reset_n,
    input logic analog_converter_reset_n,
    input logic group_one_reset_n,
    input logic i2c_reset_n
);
    logic [6:0] held, wmask;
    logic [7:0] stat;
    logic [16:0] lowc;
    logic [DUR_W-1:0] dur;
    logic [15:0] dur16;
    logic setup, acc, ctl, mapped, wr_ctl;
    // decoded bus phases and held groups
    assign held = ~{group_four_reset_n, group_three_reset_n, dma_reset_n,
        usb_reset_n, analog_converter_reset_n, group_one_reset_n, i2c_reset_n};
    assign wmask = {pwdata[7], pwdata[5:0]};
    assign stat = {held[6], 1'b0, held[5:0]};
    assign setup = psel && !penable;
    assign acc = psel && penable && pready;
    assign ctl = paddr == prs_pkg::PRS_ADDR_CONTROL;
    assign mapped = ctl || paddr == prs_pkg::PRS_ADDR_DURATION;
    assign wr_ctl = acc && pwrite && ctl && pstrb[0];
    // shadow of the duration, each byte lane as strobed
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) dur16 <= prs_pkg::PRS_DURATION_RESET;
        else if (acc && pwrite && !ctl && mapped) begin
            if (pstrb[0]) dur16[7:0] <= pwdata[7:0];
            if (pstrb[1]) dur16[15:8] <= pwdata[15:8];
        end
    end
    assign dur = dur16[DUR_W-1:0];
    // low time of the i2c line
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) lowc <= '0;
        else lowc <= i2c_reset_n ? 17'h0 : lowc + 17'h1;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence s_setup; psel && !penable; endsequence
    property p_answer; s_setup |=> pready ##1 !pready; endproperty
    property p_err; s_setup ##0 !mapped |=> pslverr && prdata == 0;
    endproperty
    property p_ok; s_setup ##0 mapped |=> !pslverr; endproperty
    property p_start; wr_ctl |=> (held & $past(wmask)) == $past(wmask);
    endproperty
    property p_cause; (held & ~$past(held)) != 0 |-> $past(wr_ctl);
    endproperty
    property p_status;
        acc && !pwrite && ctl |-> prdata == {24'h0, $past(stat)};
    endproperty
    property p_hold;
        $rose(i2c_reset_n) |-> lowc >= (dur == 0 ? 17'h1 : 17'(dur));
    endproperty
    property p_keep; wr_ctl && !pwdata[0] && !i2c_reset_n
        && 17'(dur) > lowc + 17'h2 |=> !i2c_reset_n; endproperty
    a_answer: assert property (p_answer) else $error("ready timing wrong");
    a_err: assert property (p_err) else $error("no error on unmapped");
    a_ok: assert property (p_ok) else $error("error on mapped");
    a_start: assert property (p_start) else $error("not started");
    a_cause: assert property (p_cause) else $error("no write");
    a_status: assert property (p_status) else $error("bad status");
    a_hold: assert property (p_hold) else $error("reset too short");
    a_keep: assert property (p_keep) else $error("reset cancelled");
endmodule : prs_top_checker

bind prs_top prs_top_checker #(.DUR_W(DUR_W)) u_chk (.clk_sys(clk_sys),
    .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pstrb(pstrb),
    .pready(pready), .pslverr(pslverr),
    .group_four_reset_n(group_four_reset_n),
    .group_three_reset_n(group_three_reset_n), .dma_reset_n(dma_reset_n),
    .usb_reset_n(usb_reset_n), .group_one_reset_n(group_one_reset_n),
    .analog_converter_reset_n(analog_converter_reset_n),
    .i2c_reset_n(i2c_reset_n));

// ---- test/prs_group_model.sv ----
// peripheral groups that record how long each reset was held
`timescale 1ns/1ps
module prs_group_model (
    // clock and reset
    input logic clk_sys,
    input logic rst_n,
    // group reset lines and measured hold lengths
    input logic [6:0] lines_n,
    output logic [6:0][16:0] last_len
);
    logic [6:0][16:0] run;
    // a low line holds the group in reset
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            run <= '0;
            last_len <= '0;
        end else for (int i = 0; i < 7; i++) begin
            if (!lines_n[i]) run[i] <= run[i] + 17'h1;
            else if (run[i] != 0) begin
                last_len[i] <= run[i];
                run[i] <= '0;
            end
        end
    end
endmodule : prs_group_model

// ---- test/peripheral_group_soft_reset_tb.sv ----
// self-checking bench for the peripheral group soft reset block
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_errors++; \
    $display("mismatch at %0t: got %h expected %h", $time, a, b); end end
module peripheral_group_soft_reset_tb;
    localparam logic [17:0] CTL = prs_pkg::PRS_ADDR_CONTROL;
    localparam logic [17:0] DUR = prs_pkg::PRS_ADDR_DURATION;
    logic clk_sys = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, err;
    logic [17:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [3:0] pstrb = 4'hF;
    logic pready, pslverr;
    wire logic [6:0] lines_n;
    logic [6:0][16:0] last_len;
    int n_errors = 0, n_compared = 0, cyc = 0;
    always #5 clk_sys = ~clk_sys;
    prs_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .group_four_reset_n(lines_n[6]), .group_three_reset_n(lines_n[5]),
        .dma_reset_n(lines_n[4]), .usb_reset_n(lines_n[3]),
        .analog_converter_reset_n(lines_n[2]),
        .group_one_reset_n(lines_n[1]), .i2c_reset_n(lines_n[0]));
    prs_group_model u_model (.clk_sys(clk_sys), .rst_n(rst_n),
        .lines_n(lines_n), .last_len(last_len));
    // one apb transfer; an idle edge first keeps drivers single per step
    task automatic apb(input logic w, input logic [17:0] a,
        input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    // poll the status until every group is out of reset
    task automatic wait_free();
        do apb(1'b0, CTL, 32'h0); while (rd[7:0] !== 8'h00);
    endtask : wait_free
    task automatic t_reset();
        apb(1'b0, DUR, 32'h0); `CHK(rd, 32'h8)
        apb(1'b0, CTL, 32'h0); `CHK(rd, 32'h0)
        `CHK(lines_n, 7'h7F)
    endtask : t_reset
    task automatic t_each();
        for (int i = 0; i < 7; i++) begin
            apb(1'b1, CTL, 32'h1 << prs_pkg::PRS_GROUP_BIT[i]);
            #1 `CHK(lines_n, ~(7'h01 << i))
            apb(1'b0, CTL, 32'h0);
            `CHK(rd, 32'h1 << prs_pkg::PRS_GROUP_BIT[i])
            wait_free();
            `CHK(last_len[i], 17'h08)
        end
    endtask : t_each
    // three groups at once, then a zero write in mid-hold
    task automatic t_multi();
        apb(1'b1, DUR, 32'h14);
        apb(1'b1, CTL, 32'hA1);
        apb(1'b1, CTL, 32'h0);
        apb(1'b0, CTL, 32'h0); `CHK(rd, 32'hA1)
        wait_free();
        `CHK({last_len[6], last_len[5], last_len[0]}, {3{17'h14}})
    endtask : t_multi
    task automatic t_unmapped();
        apb(1'b1, 18'h7018, 32'hFF); #1 `CHK(lines_n, 7'h7F)
        apb(1'b0, 18'h7018, 32'h0); `CHK({err, rd}, {1'b1, 32'h0})
    endtask : t_unmapped
    // byte strobes: no low lane starts nothing; a low-lane duration write
    task automatic t_lanes();
        pstrb <= 4'hE;
        apb(1'b1, CTL, 32'h01);
        pstrb <= 4'h1;
        #1 `CHK(lines_n, 7'h7F)
        apb(1'b1, DUR, 32'hFF09);
        pstrb <= 4'hF;
        apb(1'b0, DUR, 32'h0); `CHK(rd, 32'h9)
        apb(1'b1, CTL, 32'h01);
        apb(1'b0, CTL, 32'h0); `CHK(rd, 32'h1)
        wait_free();
        `CHK(last_len[0], 17'h09)
    endtask : t_lanes
    task automatic tally_and_finish();
        $display("compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish
    // hang guard, well above the fewer than two hundred cycles the run needs
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_reset();
        t_each();
        t_multi();
        t_unmapped();
        t_lanes();
        tally_and_finish();
    end
endmodule : peripheral_group_soft_reset_tb
